// *** lsw_pkg.sv ***
package lsw_pkg;

  // ==========================================
  // register map of the bus slave
  localparam int PADDR_W = 12;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_PC = 12'h004;
  localparam logic [11:0] OFF_AXY = 12'h008;
  localparam logic [11:0] OFF_SPPSW = 12'h00c;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam int CTRL_RUN = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR = 1;
  localparam int STAT_OP = 8;

  // ==========================================
  // flag positions in the status byte
  localparam int PSW_N = 7;
  localparam int PSW_V = 6;
  localparam int PSW_G = 5;
  localparam int PSW_H = 3;
  localparam int PSW_Z = 1;
  localparam int PSW_C = 0;

  // ==========================================
  // values after reset and step sizes
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] A_RST = 8'h00;
  localparam logic [7:0] X_RST = 8'h00;
  localparam logic [7:0] Y_RST = 8'h00;
  localparam logic [7:0] SP_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [7:0] IDX_STEP = 8'h01;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam int CYC_W = 3;
  localparam logic [CYC_W-1:0] CYC_ONE = 3'h1;

  // ==========================================
  // types
  typedef enum logic [10:0] {
    ST_IDLE = 11'h001, ST_OPC = 11'h002, ST_OP1 = 11'h004, ST_OP2 = 11'h008,
    ST_PLO = 11'h010, ST_PHI = 11'h020, ST_RD = 11'h040, ST_RD2 = 11'h080,
    ST_WR = 11'h100, ST_WR2 = 11'h200, ST_PAD = 11'h400
  } lsw_state_e;

  typedef enum logic [4:0] {
    K_ILL, K_LDA, K_LDX, K_LDY, K_LDM, K_STA, K_STX, K_STY, K_TAX, K_TAY,
    K_MOVE_STACKPTR_TO_X, K_TXA, K_MOVE_X_TO_STACKPTR, K_TYA, K_XAX, K_XAY, K_XMA, K_XYX, K_WORD_ADD,
    K_WORD_SUBTRACT, K_WORD_COMPARE, K_WORD_INCREMENT, K_WORD_DECREMENT, K_WORD_LOAD_PAIR, K_WORD_STORE_PAIR
  } lsw_kind_e;

  typedef enum logic [3:0] {
    M_NONE, M_IMM, M_DP, M_DPX, M_DPY, M_ABS, M_ABSY, M_IX, M_IXP, M_INDX, M_INDY
  } lsw_mode_e;

  typedef struct packed {
    lsw_kind_e kind;
    lsw_mode_e mode;
    logic [1:0] bytes;
    logic [CYC_W-1:0] cycles;
  } lsw_dec_s;

  // ==========================================
  // opcode table: kind, mode, bytes, cycles
  function automatic lsw_dec_s lsw_decode(input logic [7:0] op);
    lsw_dec_s d;
    case (op)
      8'hc4: d = '{K_LDA, M_IMM, 2'h2, 3'h2};
      8'hc5: d = '{K_LDA, M_DP, 2'h2, 3'h3};
      8'hc6: d = '{K_LDA, M_DPX, 2'h2, 3'h4};
      8'hc7: d = '{K_LDA, M_ABS, 2'h3, 3'h4};
      8'hd5: d = '{K_LDA, M_ABSY, 2'h3, 3'h5};
      8'hd6: d = '{K_LDA, M_INDX, 2'h2, 3'h6};
      8'hd7: d = '{K_LDA, M_INDY, 2'h2, 3'h6};
      8'hd4: d = '{K_LDA, M_IX, 2'h1, 3'h3};
      8'hdb: d = '{K_LDA, M_IXP, 2'h1, 3'h4};
      8'he4: d = '{K_LDM, M_DP, 2'h3, 3'h5};
      8'h1e: d = '{K_LDX, M_IMM, 2'h2, 3'h2};
      8'hcc: d = '{K_LDX, M_DP, 2'h2, 3'h3};
      8'hcd: d = '{K_LDX, M_DPY, 2'h2, 3'h4};
      8'hdc: d = '{K_LDX, M_ABS, 2'h3, 3'h4};
      8'h3e: d = '{K_LDY, M_IMM, 2'h2, 3'h2};
      8'hc9: d = '{K_LDY, M_DP, 2'h2, 3'h3};
      8'hd9: d = '{K_LDY, M_DPX, 2'h2, 3'h4};
      8'hd8: d = '{K_LDY, M_ABS, 2'h3, 3'h4};
      8'he5: d = '{K_STA, M_DP, 2'h2, 3'h4};
      8'he6: d = '{K_STA, M_DPX, 2'h2, 3'h5};
      8'he7: d = '{K_STA, M_ABS, 2'h3, 3'h5};
      8'hf5: d = '{K_STA, M_ABSY, 2'h3, 3'h6};
      8'hf6: d = '{K_STA, M_INDX, 2'h2, 3'h7};
      8'hf7: d = '{K_STA, M_INDY, 2'h2, 3'h7};
      8'hf4: d = '{K_STA, M_IX, 2'h1, 3'h4};
      8'hfb: d = '{K_STA, M_IXP, 2'h1, 3'h4};
      8'hec: d = '{K_STX, M_DP, 2'h2, 3'h4};
      8'hed: d = '{K_STX, M_DPY, 2'h2, 3'h5};
      8'hfc: d = '{K_STX, M_ABS, 2'h3, 3'h5};
      8'he9: d = '{K_STY, M_DP, 2'h2, 3'h4};
      8'hf9: d = '{K_STY, M_DPX, 2'h2, 3'h5};
      8'hf8: d = '{K_STY, M_ABS, 2'h3, 3'h5};
      8'he8: d = '{K_TAX, M_NONE, 2'h1, 3'h2};
      8'h9f: d = '{K_TAY, M_NONE, 2'h1, 3'h2};
      8'hae: d = '{K_MOVE_STACKPTR_TO_X, M_NONE, 2'h1, 3'h2};
      8'hc8: d = '{K_TXA, M_NONE, 2'h1, 3'h2};
      8'h8e: d = '{K_MOVE_X_TO_STACKPTR, M_NONE, 2'h1, 3'h2};
      8'hbf: d = '{K_TYA, M_NONE, 2'h1, 3'h2};
      8'hee: d = '{K_XAX, M_NONE, 2'h1, 3'h4};
      8'hde: d = '{K_XAY, M_NONE, 2'h1, 3'h4};
      8'hbc: d = '{K_XMA, M_DP, 2'h2, 3'h5};
      8'had: d = '{K_XMA, M_DPX, 2'h2, 3'h6};
      8'hbb: d = '{K_XMA, M_IX, 2'h1, 3'h5};
      8'hfe: d = '{K_XYX, M_NONE, 2'h1, 3'h4};
      8'h1d: d = '{K_WORD_ADD, M_DP, 2'h2, 3'h5};
      8'h3d: d = '{K_WORD_SUBTRACT, M_DP, 2'h2, 3'h5};
      8'h5d: d = '{K_WORD_COMPARE, M_DP, 2'h2, 3'h4};
      8'hbd: d = '{K_WORD_DECREMENT, M_DP, 2'h2, 3'h6};
      8'h9d: d = '{K_WORD_INCREMENT, M_DP, 2'h2, 3'h6};
      8'h7d: d = '{K_WORD_LOAD_PAIR, M_DP, 2'h2, 3'h5};
      8'hdd: d = '{K_WORD_STORE_PAIR, M_DP, 2'h2, 3'h5};
      default: d = '{K_ILL, M_NONE, 2'h1, 3'h1};
    endcase
    return d;
  endfunction : lsw_decode

endpackage : lsw_pkg

// *** lsw_word_alu.sv ***
`timescale 1ns/1ps
module lsw_word_alu #(
  parameter int W = 16 // operand width
) (
  input logic sub, // 1: a - b, 0: a + b
  input logic [W-1:0] a, // left operand
  input logic [W-1:0] b, // right operand
  output logic [W-1:0] res, // result
  output logic flag_n, // sign of result
  output logic flag_v, // signed overflow
  output logic flag_h, // carry out of bit W-5
  output logic flag_z, // result is zero
  output logic flag_c // carry out, or no borrow
);

  logic [W-1:0] bb;
  logic [W:0] sum;

  // subtraction as a + ~b + 1, so carry means no borrow
  assign bb = sub ? ~b : b;
  assign sum = {1'b0, a} + {1'b0, bb} + {{W{1'b0}}, sub};
  assign res = sum[W-1:0];
  assign flag_n = sum[W-1];
  assign flag_v = (a[W-1] == bb[W-1]) && (sum[W-1] != a[W-1]);
  assign flag_h = a[W-4] ^ bb[W-4] ^ sum[W-4];
  assign flag_z = (sum[W-1:0] == {W{1'b0}});
  assign flag_c = sum[W];

endmodule : lsw_word_alu

// *** lsw_core.sv ***
`timescale 1ns/1ps
// Summary of operation
// - load accumulator, set N Z, auto-increment X in the (X)+ mode only
// - immediate to memory, three bytes, five cycles
// - store accumulator, flags kept, indirect seven cycles
// - store accumulator at X, then X plus one
// - store X in three modes, flags kept
// - store Y in three modes, flags kept
// - copy accumulator into X or Y, N Z
// - copy X or Y into accumulator, N Z
// - stack pointer to X and back, N Z
// - swap accumulator with X or Y, four cycles
// - swap accumulator with memory, N Z
// - swap X and Y, four cycles, flags kept
// - word add pair into Y:A, N V H Z C
// - word subtract pair from Y:A, N V H Z C
// - word compare sets N Z C only
// - word decrement in memory, N Z, six cycles
// - word increment in memory, N Z, six cycles
// - word store keeps flags, word load sets N Z
module lsw_core (
  input logic clk, // system clock
  input logic rst, // synchronous reset, active high
  input logic psel, // apb select
  input logic penable, // apb access phase
  input logic pwrite, // apb direction, 1 = write
  input logic [lsw_pkg::PADDR_W-1:0] paddr, // apb byte address
  input logic [31:0] pwdata, // apb write data
  input logic [3:0] pstrb, // apb byte lanes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb transfer done
  output logic pslverr, // apb error answer
  output logic [15:0] mem_addr, // core bus address
  output logic mem_rd, // core bus read strobe
  output logic mem_wr, // core bus write strobe
  output logic [7:0] mem_wdata, // core bus write data
  input logic [7:0] mem_rdata // core bus read data, same cycle
);
  import lsw_pkg::*;

  // ==========================================
  // state
  typedef struct packed {
    lsw_state_e st;
    lsw_dec_s dec;
    logic [CYC_W-1:0] cyc;
    logic [15:0] pc;
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] sp;
    logic [7:0] psw;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] vlo;
    logic [7:0] vhi;
    logic [15:0] ea;
    logic run;
    logic err;
    logic [7:0] last_op;
    logic [15:0] maddr;
    logic mrd;
    logic mwr;
    logic [7:0] mwd;
    logic rdy;
    logic slverr;
    logic [31:0] rdata;
  } lsw_core_s;

  lsw_core_s s;
  lsw_core_s n;
  lsw_dec_s dd;
  lsw_state_e nxt;
  logic done;
  logic last;
  logic busy;
  logic acc_prep;
  logic acc_do;
  logic hit;
  logic [31:0] rmux;
  logic [31:0] wv;
  logic [7:0] opnd_lo;
  logic [7:0] opnd_hi;
  logic [7:0] pofs;
  logic alu_sub;
  logic [15:0] alu_a;
  logic [15:0] alu_b;
  logic [15:0] alu_res;
  logic alu_n;
  logic alu_v;
  logic alu_h;
  logic alu_z;
  logic alu_c;

  // ==========================================
  // helpers
  function automatic logic rd_word(input lsw_kind_e k);
    return k inside {K_WORD_ADD, K_WORD_SUBTRACT, K_WORD_COMPARE, K_WORD_INCREMENT, K_WORD_DECREMENT, K_WORD_LOAD_PAIR};
  endfunction : rd_word

  function automatic logic wr_word(input lsw_kind_e k);
    return k inside {K_WORD_INCREMENT, K_WORD_DECREMENT, K_WORD_STORE_PAIR};
  endfunction : wr_word

  function automatic logic needs_rd(input lsw_dec_s d);
    return ((d.kind inside {K_LDA, K_LDX, K_LDY}) && (d.mode != M_IMM)) ||
           (d.kind == K_XMA) || rd_word(d.kind);
  endfunction : needs_rd

  function automatic logic needs_wr(input lsw_kind_e k);
    return k inside {K_STA, K_STX, K_STY, K_LDM, K_XMA, K_WORD_INCREMENT, K_WORD_DECREMENT, K_WORD_STORE_PAIR};
  endfunction : needs_wr

  // bus phases still owed after the operand phase
  function automatic lsw_state_e after_rd(input lsw_dec_s d);
    return needs_wr(d.kind) ? ST_WR : ST_PAD;
  endfunction : after_rd

  function automatic lsw_state_e after_ptr(input lsw_dec_s d);
    return needs_rd(d) ? ST_RD : after_rd(d);
  endfunction : after_ptr

  function automatic lsw_state_e after_ops(input lsw_dec_s d);
    return (d.mode inside {M_INDX, M_INDY}) ? ST_PLO : after_ptr(d);
  endfunction : after_ops

  function automatic lsw_state_e next_step(input lsw_state_e st, input lsw_dec_s d);
    lsw_state_e r;
    case (st)
      ST_OPC: r = (d.bytes != 2'h1) ? ST_OP1 : after_ops(d);
      ST_OP1: r = (d.bytes == 2'h3) ? ST_OP2 : after_ops(d);
      ST_OP2: r = after_ops(d);
      ST_PLO: r = ST_PHI;
      ST_PHI: r = after_ptr(d);
      ST_RD: r = rd_word(d.kind) ? ST_RD2 : after_rd(d);
      ST_RD2: r = after_rd(d);
      ST_WR: r = wr_word(d.kind) ? ST_WR2 : ST_PAD;
      default: r = ST_PAD;
    endcase
    return r;
  endfunction : next_step

  // direct page: page picked by the G flag
  function automatic logic [15:0] dp(input logic [7:0] p, input logic [7:0] o);
    return {7'h00, p[PSW_G], o};
  endfunction : dp

  function automatic logic [7:0] nz8(input logic [7:0] p, input logic [7:0] v);
    logic [7:0] r;
    r = p;
    r[PSW_N] = v[7];
    r[PSW_Z] = (v == 8'h00);
    return r;
  endfunction : nz8

  function automatic logic [7:0] nz16(input logic [7:0] p, input logic [15:0] v);
    logic [7:0] r;
    r = p;
    r[PSW_N] = v[15];
    r[PSW_Z] = (v == 16'h0000);
    return r;
  endfunction : nz16

  function automatic logic [15:0] eff_addr(input lsw_core_s c);
    logic [15:0] r;
    case (c.dec.mode)
      M_DPX: r = dp(c.psw, c.b1 + c.x);
      M_DPY: r = dp(c.psw, c.b1 + c.y);
      M_ABS: r = {c.b2, c.b1};
      M_ABSY: r = {c.b2, c.b1} + {8'h00, c.y};
      M_IX, M_IXP: r = dp(c.psw, c.x);
      M_INDX, M_INDY: r = c.ea;
      default: r = dp(c.psw, c.b1);
    endcase
    return r;
  endfunction : eff_addr

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] w,
                                         input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = w[8*i +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // ==========================================
  // word arithmetic
  assign opnd_lo = (s.st == ST_RD || s.st == ST_OP1) ? mem_rdata : s.vlo;
  assign opnd_hi = (s.st == ST_RD2) ? mem_rdata : s.vhi;
  assign alu_sub = s.dec.kind inside {K_WORD_SUBTRACT, K_WORD_COMPARE, K_WORD_DECREMENT};
  assign alu_a = (s.dec.kind inside {K_WORD_INCREMENT, K_WORD_DECREMENT}) ? {opnd_hi, opnd_lo} : {s.y, s.a};
  assign alu_b = (s.dec.kind inside {K_WORD_INCREMENT, K_WORD_DECREMENT}) ? WORD_ONE : {opnd_hi, opnd_lo};

  lsw_word_alu #(
    .W(16)
  ) u_alu (
    .sub(alu_sub),
    .a(alu_a),
    .b(alu_b),
    .res(alu_res),
    .flag_n(alu_n),
    .flag_v(alu_v),
    .flag_h(alu_h),
    .flag_z(alu_z),
    .flag_c(alu_c)
  );

  // ==========================================
  // next state
  always_comb begin
    n = s;
    wv = 32'h0000_0000;
    rmux = 32'h0000_0000;
    hit = 1'b1;
    dd = (s.st == ST_OPC) ? lsw_decode(mem_rdata) : s.dec;
    nxt = next_step(s.st, dd);
    done = (nxt == ST_PAD);
    last = done && (s.cyc == dd.cycles - CYC_ONE);
    busy = s.run | (s.st != ST_IDLE);

    // apb slave, one wait state
    acc_prep = psel & penable & ~s.rdy;
    acc_do = psel & penable & s.rdy;
    case (paddr)
      OFF_CTRL: rmux[CTRL_RUN] = s.run;
      OFF_PC: rmux[15:0] = s.pc;
      OFF_AXY: rmux[23:0] = {s.y, s.x, s.a};
      OFF_SPPSW: rmux[15:0] = {s.psw, s.sp};
      OFF_STATUS: begin
        rmux[STAT_BUSY] = busy;
        rmux[STAT_ERR] = s.err;
        rmux[STAT_OP +: 8] = s.last_op;
      end
      default: hit = 1'b0;
    endcase
    n.rdy = acc_prep;
    n.slverr = acc_prep & (~hit | (pwrite & busy & (paddr inside {OFF_PC, OFF_AXY, OFF_SPPSW})));
    n.rdata = (acc_prep & ~pwrite & hit) ? rmux : 32'h0000_0000;
    if (acc_do && pwrite && !s.slverr) begin
      wv = wmerge(rmux, pwdata, pstrb);
      case (paddr)
        OFF_CTRL: n.run = wv[CTRL_RUN];
        OFF_PC: n.pc = wv[15:0];
        OFF_AXY: {n.y, n.x, n.a} = wv[23:0];
        OFF_SPPSW: {n.psw, n.sp} = wv[15:0];
        OFF_STATUS: begin
          if (pstrb[0] && pwdata[STAT_ERR]) begin
            n.err = 1'b0;
          end
        end
        default: n.run = s.run;
      endcase
    end

    // capture what the bus returned this cycle
    case (s.st)
      ST_OPC: begin
        n.dec = dd;
        n.last_op = mem_rdata;
        n.pc = s.pc + PC_STEP;
      end
      ST_OP1: begin
        n.b1 = mem_rdata;
        n.vlo = mem_rdata;
        n.pc = s.pc + PC_STEP;
      end
      ST_OP2: begin
        n.b2 = mem_rdata;
        n.pc = s.pc + PC_STEP;
      end
      ST_PLO: n.ea[7:0] = mem_rdata;
      ST_PHI: begin
        if (s.dec.mode == M_INDY) begin
          n.ea = {mem_rdata, s.ea[7:0]} + {8'h00, s.y};
        end else begin
          n.ea = {mem_rdata, s.ea[7:0]};
        end
      end
      ST_RD: n.vlo = mem_rdata;
      ST_RD2: n.vhi = mem_rdata;
      default: n.cyc = s.cyc;
    endcase

    // sequencing and commit
    if (s.st == ST_IDLE) begin
      if (s.run) begin
        n.st = ST_OPC;
        n.cyc = '0;
      end
    end else if (s.st == ST_OPC && dd.kind == K_ILL) begin
      // unknown opcode: halt with pc on it
      n.st = ST_IDLE;
      n.pc = s.pc;
      n.run = 1'b0;
      n.err = 1'b1;
    end else if (last) begin
      n.st = n.run ? ST_OPC : ST_IDLE;
      n.cyc = '0;
      case (dd.kind)
        K_LDA: begin
          n.a = opnd_lo;
          n.psw = nz8(s.psw, opnd_lo);
        end
        K_LDX: begin
          n.x = opnd_lo;
          n.psw = nz8(s.psw, opnd_lo);
        end
        K_LDY: begin
          n.y = opnd_lo;
          n.psw = nz8(s.psw, opnd_lo);
        end
        K_TAX: begin
          n.x = s.a;
          n.psw = nz8(s.psw, s.a);
        end
        K_TAY: begin
          n.y = s.a;
          n.psw = nz8(s.psw, s.a);
        end
        K_TXA: begin
          n.a = s.x;
          n.psw = nz8(s.psw, s.x);
        end
        K_TYA: begin
          n.a = s.y;
          n.psw = nz8(s.psw, s.y);
        end
        K_MOVE_STACKPTR_TO_X: begin
          n.x = s.sp;
          n.psw = nz8(s.psw, s.sp);
        end
        K_MOVE_X_TO_STACKPTR: begin
          n.sp = s.x;
          n.psw = nz8(s.psw, s.x);
        end
        K_XAX: begin
          n.a = s.x;
          n.x = s.a;
        end
        K_XAY: begin
          n.a = s.y;
          n.y = s.a;
        end
        K_XYX: begin
          n.x = s.y;
          n.y = s.x;
        end
        K_XMA: begin
          n.a = opnd_lo;
          n.psw = nz8(s.psw, opnd_lo);
        end
        K_WORD_ADD, K_WORD_SUBTRACT: begin
          {n.y, n.a} = alu_res;
          n.psw[PSW_N] = alu_n;
          n.psw[PSW_V] = alu_v;
          n.psw[PSW_H] = alu_h;
          n.psw[PSW_Z] = alu_z;
          n.psw[PSW_C] = alu_c;
        end
        K_WORD_COMPARE: begin
          n.psw[PSW_N] = alu_n;
          n.psw[PSW_Z] = alu_z;
          n.psw[PSW_C] = alu_c;
        end
        K_WORD_INCREMENT, K_WORD_DECREMENT: n.psw = nz16(s.psw, alu_res);
        K_WORD_LOAD_PAIR: begin
          {n.y, n.a} = {opnd_hi, opnd_lo};
          n.psw = nz16(s.psw, {opnd_hi, opnd_lo});
        end
        default: n.psw = s.psw;
      endcase
      if (dd.mode == M_IXP) begin
        n.x = s.x + IDX_STEP;
      end
    end else begin
      n.st = done ? ST_PAD : nxt;
      n.cyc = s.cyc + CYC_ONE;
    end

    // bus request for the coming cycle
    pofs = (n.dec.mode == M_INDX) ? n.b1 + n.x : n.b1;
    n.mrd = 1'b0;
    n.mwr = 1'b0;
    n.mwd = 8'h00;
    n.maddr = n.pc;
    case (n.st)
      ST_OPC, ST_OP1, ST_OP2: n.mrd = 1'b1;
      ST_PLO: begin
        n.mrd = 1'b1;
        n.maddr = dp(n.psw, pofs);
      end
      ST_PHI: begin
        n.mrd = 1'b1;
        n.maddr = dp(n.psw, pofs + IDX_STEP);
      end
      ST_RD: begin
        n.mrd = 1'b1;
        n.maddr = eff_addr(n);
      end
      ST_RD2: begin
        n.mrd = 1'b1;
        n.maddr = dp(n.psw, n.b1 + IDX_STEP);
      end
      ST_WR: begin
        n.mwr = 1'b1;
        n.maddr = eff_addr(n);
        case (n.dec.kind)
          K_STX: n.mwd = n.x;
          K_STY: n.mwd = n.y;
          K_LDM: n.mwd = n.b2;
          K_WORD_INCREMENT, K_WORD_DECREMENT: n.mwd = alu_res[7:0];
          default: n.mwd = n.a;
        endcase
      end
      ST_WR2: begin
        n.mwr = 1'b1;
        n.maddr = dp(n.psw, n.b1 + IDX_STEP);
        n.mwd = (n.dec.kind == K_WORD_STORE_PAIR) ? n.y : alu_res[15:8];
      end
      default: n.mrd = 1'b0;
    endcase
  end

  // ==========================================
  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.pc <= PC_RST;
      s.a <= A_RST;
      s.x <= X_RST;
      s.y <= Y_RST;
      s.sp <= SP_RST;
      s.psw <= PSW_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.rdata;
  assign pready = s.rdy;
  assign pslverr = s.slverr;
  assign mem_addr = s.maddr;
  assign mem_rd = s.mrd;
  assign mem_wr = s.mwr;
  assign mem_wdata = s.mwd;

endmodule : lsw_core

// *** lsw_props.sv ***
`timescale 1ns/1ps
// ========================================
// port checker for the core
module lsw_props (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] pwdata, // wdata
  input wire logic [3:0] pstrb, // lanes
  input wire logic [31:0] prdata, // rdata
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [15:0] mem_addr, // bus addr
  input wire logic mem_rd, // bus read
  input wire logic mem_wr, // bus write
  input wire logic [7:0] mem_wdata, // bus wdata
  input wire logic [7:0] mem_rdata // bus rdata
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  a_ready_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("no answer after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_wdata_idle: assert property (!mem_wr |-> mem_wdata == 8'h00)
    else $error("write data without strobe");
  a_bus_excl: assert property (!(mem_rd && mem_wr))
    else $error("read and write together");
  a_reset_quiet: assert property ($past(rst) |-> !mem_rd && !mem_wr && !pready && mem_addr == 16'h0)
    else $error("bus active after reset");
  a_word_wr_pair: assert property (mem_wr && $past(mem_wr) |-> mem_addr[15:8] == $past(mem_addr[15:8]) && mem_addr[7:0] == $past(mem_addr[7:0]) + 8'h01)
    else $error("word write not low then high in page");
  c_err: cover property (pready && pslverr);
  c_pair: cover property (mem_wr ##1 mem_wr);
  c_read: cover property (pready && !pwrite);
endmodule : lsw_props

// *** lsw_mem.sv ***
`timescale 1ns/1ps
// ========================================
// far-side memory, async read
module lsw_mem (
  input wire logic clk, // clock
  input wire logic [15:0] addr, // address
  input wire logic rd, // read strobe
  input wire logic wr, // write strobe
  input wire logic [7:0] wdata, // write data
  output logic [7:0] rdata // read data
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  // released bus shows inverse of last byte
  assign rdata = rd ? mem[addr] : ~last;
  always @(posedge clk) begin
    if (rd) last <= mem[addr];
    if (wr) mem[addr] <= wdata;
  end
endmodule : lsw_mem

// *** testbench.sv ***
`timescale 1ns/1ps
// ========================================
// bench
module testbench;
  import lsw_pkg::*;
  typedef struct {logic [31:0] prog; int nb; logic [23:0] ai; logic [15:0] mi; logic [23:0] ao;
    logic [15:0] ps; logic [15:0] mo; int cy;} lsw_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr, mem_rd, mem_wr;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [31:0] r;
  logic e;
  int fails = 0, n_compared = 0, cyc = 0, t0 = 0, t1 = 0, nb = 0;
  lsw_row_s rows [30] = '{
    '{'h80c4, 2, 'h0, 'h1234, 'h80, 'hc900, 'h1234, 2},
    '{'hdb, 1, 'h8000, 'h127e, 'h817e, 'h4900, 'h127e, 4},
    '{'h5a80e4, 3, 'h0, 'h1234, 'h0, 'hcb00, 'h125a, 5},
    '{'h80e5, 2, 'h77, 'h1234, 'h77, 'hcb00, 'h1277, 4},
    '{'h80f7, 2, 'h10000, 'h0090, 'h10000, 'hcb00, 'h0090, 7},
    '{'hfb, 1, 'h8199, 'h1234, 'h8299, 'hcb00, 'h9934, 4},
    '{'h80ec, 2, 'h3c00, 'h1234, 'h3c00, 'hcb00, 'h123c, 4},
    '{'h81e9, 2, 'h560000, 'h1234, 'h560000, 'hcb00, 'h5634, 4},
    '{'he8, 1, 'h5500, 'h1234, 'h0, 'h4b00, 'h1234, 2},
    '{'h9f, 1, 'h5, 'h1234, 'h50005, 'h4900, 'h1234, 2},
    '{'hc8, 1, 'hff00, 'h1234, 'hffff, 'hc900, 'h1234, 2},
    '{'hbf, 1, 'hf00000, 'h1234, 'hf000f0, 'hc900, 'h1234, 2},
    '{'hae, 1, 'h1100, 'h1234, 'h0, 'h4b00, 'h1234, 2},
    '{'h8e, 1, 'h8000, 'h1234, 'h8000, 'hc980, 'h1234, 2},
    '{'hee, 1, 'h1234, 'h1234, 'h3412, 'hcb00, 'h1234, 4},
    '{'hde, 1, 'h120034, 'h1234, 'h340012, 'hcb00, 'h1234, 4},
    '{'h80bc, 2, 'h80, 'h1200, 'h0, 'h4b00, 'h1280, 5},
    '{'hfe, 1, 'h341200, 'h1234, 'h123400, 'hcb00, 'h1234, 4},
    '{'h801d, 2, 'h120034, 'hedcc, 'h0, 'h0b00, 'hedcc, 5},
    '{'h803d, 2, 'h800000, 'h0001, 'h7f00ff, 'h4100, 'h0001, 5},
    '{'h805d, 2, 'h120034, 'h1234, 'h120034, 'h4b00, 'h1234, 4},
    '{'h80bd, 2, 'h0, 'h0000, 'h0, 'hc900, 'hffff, 6},
    '{'h809d, 2, 'h0, 'hffff, 'h0, 'h4b00, 'h0000, 6},
    '{'h807d, 2, 'h0, 'h8001, 'h800001, 'hc900, 'h8001, 5},
    '{'h80dd, 2, 'h560078, 'h1234, 'h560078, 'hcb00, 'h5678, 5},
    '{'h7fd6, 2, 'h100, 'h0080, 'h180, 'hc900, 'h0080, 6},
    '{'h007ff5, 3, 'h10055, 'h1234, 'h10055, 'hcb00, 'h1255, 6},
    '{'h7fed, 2, 'h16600, 'h1234, 'h16600, 'hcb00, 'h1266, 5},
    '{'h80d8, 3, 'h0, 'h1234, 'h340000, 'h4900, 'h1234, 4},
    '{'h001e, 2, 'h7700, 'h1234, 'h0, 'h4b00, 'h1234, 2}
  };

  lsw_core u_lsw_core (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  lsw_mem u_lsw_mem (.clk(clk), .addr(mem_addr), .rd(mem_rd), .wr(mem_wr), .wdata(mem_wdata),
    .rdata(mem_rdata));

  initial forever #5 clk = ~clk;

  // opcode fetch times and hang limit
  always @(posedge clk) begin
    cyc++;
    if (mem_rd && mem_addr == 16'h0) t0 = cyc;
    if (mem_rd && mem_addr == 16'(nb)) t1 = cyc;
    if (cyc == 20000) begin
      fails++;
      $display("MISMATCH %0t cycle limit reached", $time);
      results();
    end
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      fails++;
      $display("MISMATCH %0t no bus answer", $time);
    end
    @(posedge clk);
  endtask : apb

  // wait for halt on the trailing unknown opcode, then clear err
  task automatic halt();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
      n++;
    end while (r[STAT_BUSY] !== 1'b0 && n < 40);
    chk(r & 32'hff, 32'h2);
    apb(1'b1, OFF_STATUS, 32'h2);
  endtask : halt

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      nb = rows[i].nb;
      for (int k = 0; k < 4; k++) u_lsw_mem.mem[k] = rows[i].prog[8*k +: 8];
      u_lsw_mem.mem[16'h80] = rows[i].mi[7:0];
      u_lsw_mem.mem[16'h81] = rows[i].mi[15:8];
      apb(1'b1, OFF_PC, 32'h0);
      apb(1'b1, OFF_AXY, {8'h0, rows[i].ai});
      apb(1'b1, OFF_SPPSW, 32'hcb00);
      apb(1'b1, OFF_CTRL, 32'h1);
      halt();
      apb(1'b0, OFF_AXY, 32'h0);
      chk(r, {8'h0, rows[i].ao});
      apb(1'b0, OFF_SPPSW, 32'h0);
      chk(r, {16'h0, rows[i].ps});
      chk({16'h0, u_lsw_mem.mem[16'h81], u_lsw_mem.mem[16'h80]}, {16'h0, rows[i].mo});
      chk(32'(t1 - t0), 32'(rows[i].cy));
    end
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    apb(1'b0, 12'h006, 32'h0);
    chk({31'h0, e}, 32'h1);
    // refused PC write while the word increment runs
    nb = 2;
    u_lsw_mem.mem[0] = 8'h9d;
    u_lsw_mem.mem[1] = 8'h80;
    u_lsw_mem.mem[16'h80] = 8'hff;
    u_lsw_mem.mem[16'h81] = 8'h00;
    apb(1'b1, OFF_PC, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h1);
    apb(1'b1, OFF_PC, 32'h40);
    chk({31'h0, e}, 32'h1);
    halt();
    apb(1'b0, OFF_PC, 32'h0);
    chk(r & 32'hffff, 32'h2);
    chk({16'h0, u_lsw_mem.mem[16'h81], u_lsw_mem.mem[16'h80]}, 32'h0100);
    chk(32'(t1 - t0), 32'h6);
    // reset after the halt brings every register back
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, OFF_AXY, 32'h0);
    chk(r, {8'h0, Y_RST, X_RST, A_RST});
    apb(1'b0, OFF_SPPSW, 32'h0);
    chk(r, {16'h0, PSW_RST, SP_RST});
    apb(1'b0, OFF_PC, 32'h0);
    chk(r, {16'h0, PC_RST});
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(r, 32'h0);
    // only the second byte lane lands
    pstrb <= 4'h2;
    apb(1'b1, OFF_AXY, 32'h00aabbcc);
    pstrb <= 4'hf;
    apb(1'b0, OFF_AXY, 32'h0);
    chk(r, 32'h0000bb00);
    results();
  end
endmodule : testbench

bind lsw_core lsw_props u_lsw_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
